// *** core/asr_host.sv ***
`timescale 1ns/1ns
`default_nettype none

module asr_host (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_req,
    input wire logic i_write,
    input wire logic [asr_pkg::ADDR_W-1:0] i_addr,
    input wire logic [asr_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_sleep,
    output logic o_ready,
    output logic o_rvalid,
    output logic [asr_pkg::DATA_W-1:0] o_rdata,
    output logic o_asleep,
    output logic [asr_pkg::ADDR_W-1:0] o_mem_addr,
    output logic o_mem_cs_n,
    output logic o_mem_oe_n,
    output logic o_mem_we_n,
    input wire logic [asr_pkg::DATA_W-1:0] i_mem_dq,
    output logic [asr_pkg::DATA_W-1:0] o_mem_dq,
    output logic o_mem_dq_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks.

    // The counter must hold the longest wait.
    if (asr_pkg::RECOVER_CYC >= (1 << asr_pkg::CNT_W) ||
        asr_pkg::WRITE_CYC >= (1 << asr_pkg::CNT_W)) begin : g_chk
        $error("Cycle counter too narrow.");
    end

    localparam logic [7:0] RD_END = 8'(asr_pkg::READ_CYC);
    // Address and strobes fall together, so the strobe low time must cover
    // the address-to-write-end time as well as the select-to-end time.
    localparam int WR_LOW_CYC =
        (asr_pkg::ADDR_WRITE_CYC > asr_pkg::CS_WRITE_CYC) ?
        asr_pkg::ADDR_WRITE_CYC : asr_pkg::CS_WRITE_CYC;
    localparam logic [7:0] WR_LOW = 8'(WR_LOW_CYC);
    localparam logic [7:0] WR_END = 8'(asr_pkg::WRITE_CYC);
    localparam logic [7:0] GAP_END = 8'(asr_pkg::HIZ_CYC);
    localparam logic [7:0] WAKE_END = 8'(asr_pkg::RECOVER_CYC);

    ////////////////////////////////////////////////////////////////////////
    // Pin input synchroniser: the read bus comes from outside our clock.

    logic [asr_pkg::DATA_W-1:0] dq_meta; // First stage, read only by second.
    logic [asr_pkg::DATA_W-1:0] dq_sync; // Second stage, safe to use.

    // Two flip-flops on the data bus before any logic looks at it.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            dq_meta <= '0;
            dq_sync <= '0;
        end else begin
            dq_meta <= i_mem_dq;
            dq_sync <= dq_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state.

    asr_pkg::asr_state_t state, next_state;
    logic [7:0] cnt, next_cnt;             // Cycles spent in this state.
    asr_pkg::asr_pins_t pins, next_pins;   // Registered control pins.
    logic [asr_pkg::DATA_W-1:0] wdata, next_wdata; // Latched write data.
    logic dq_oe, next_dq_oe;               // Host drive enable.
    logic [asr_pkg::DATA_W-1:0] rdata, next_rdata; // Captured read word.
    logic rvalid, next_rvalid;             // One-cycle read done pulse.

    // Next-state logic. Every cycle is long enough for the slowest grade,
    // trading speed for one timing set that serves all three.
    always_comb begin
        next_state = state;
        next_cnt = cnt + 8'h01;
        next_pins = pins;
        next_wdata = wdata;
        next_dq_oe = dq_oe;
        next_rdata = rdata;
        next_rvalid = 1'b0;
        unique case (state)
            asr_pkg::ST_IDLE: begin
                next_cnt = 8'h00;
                if (i_sleep) begin
                    // Deselected already, retention may start at once.
                    next_state = asr_pkg::ST_SLEEP;
                end else if (i_req && i_write) begin
                    // Address and strobes together: setup of 0 ns.
                    next_pins.addr = i_addr;
                    next_pins.cs_n = 1'b0;
                    next_pins.we_n = 1'b0;
                    next_pins.oe_n = 1'b1;
                    next_wdata = i_wdata;
                    next_dq_oe = 1'b1;
                    next_state = asr_pkg::ST_WRITE;
                end else if (i_req) begin
                    // Address set with select, write enable held high.
                    next_pins.addr = i_addr;
                    next_pins.cs_n = 1'b0;
                    next_pins.oe_n = 1'b0;
                    next_pins.we_n = 1'b1;
                    next_state = asr_pkg::ST_READ;
                end
            end
            asr_pkg::ST_READ: begin
                // Sample after the access time plus synchroniser delay.
                // The bus is only valid at the end of the access time, so
                // it is taken one cycle later to leave setup margin.
                if (cnt == RD_END + 8'h02) begin
                    next_rdata = dq_sync;
                    next_rvalid = 1'b1;
                    next_pins.cs_n = 1'b1;
                    next_pins.oe_n = 1'b1;
                    next_cnt = 8'h00;
                    next_state = asr_pkg::ST_GAP;
                end
            end
            asr_pkg::ST_WRITE: begin
                // Both strobes rise together, so recovery starts there.
                if (cnt == WR_LOW - 8'h01) begin
                    next_pins.cs_n = 1'b1;
                    next_pins.we_n = 1'b1;
                end
                // Data held one cycle past the strobes' rise.
                if (cnt == WR_LOW) begin
                    next_dq_oe = 1'b0;
                end
                if (cnt == WR_END - 8'h01) begin
                    next_cnt = 8'h00;
                    next_state = asr_pkg::ST_IDLE;
                end
            end
            asr_pkg::ST_GAP: begin
                // Wait for the memory to release the bus before reuse.
                if (cnt == GAP_END - 8'h01) begin
                    next_cnt = 8'h00;
                    next_state = asr_pkg::ST_IDLE;
                end
            end
            asr_pkg::ST_SLEEP: begin
                next_cnt = 8'h00;
                if (!i_sleep) begin
                    next_state = asr_pkg::ST_WAKE;
                end
            end
            asr_pkg::ST_WAKE: begin
                // A full read cycle must pass before normal access.
                if (cnt == WAKE_END - 8'h01) begin
                    next_cnt = 8'h00;
                    next_state = asr_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = asr_pkg::ST_IDLE;
                next_pins.cs_n = 1'b1;
                next_dq_oe = 1'b0;
            end
        endcase
    end

    // Registers of the sequencer; reset leaves the memory deselected.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= asr_pkg::ST_IDLE;
            cnt <= 8'h00;
            pins <= '{addr: '0, cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
            wdata <= '0;
            dq_oe <= 1'b0;
            rdata <= '0;
            rvalid <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            pins <= next_pins;
            wdata <= next_wdata;
            dq_oe <= next_dq_oe;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign o_ready = (state == asr_pkg::ST_IDLE) && !i_sleep;
    assign o_rvalid = rvalid;
    assign o_rdata = rdata;
    assign o_asleep = (state == asr_pkg::ST_SLEEP);
    assign o_mem_addr = pins.addr;
    assign o_mem_cs_n = pins.cs_n;
    assign o_mem_oe_n = pins.oe_n;
    assign o_mem_we_n = pins.we_n;
    assign o_mem_dq = wdata;
    assign o_mem_dq_oe = dq_oe;

    ////////////////////////////////////////////////////////////////////////
    // Assertions. All of them sample on the one clock and pause in reset.

    default clocking cb_asr @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    // A write starts when write enable is first seen low with select low.
    sequence s_wr_start;
        $fell(o_mem_we_n) && !o_mem_cs_n;
    endsequence

    chk_read_we_high: assert property (
        (!o_mem_cs_n && !o_mem_oe_n) |-> o_mem_we_n)
        else $error("Write enable low during a read.");
    chk_read_spacing: assert property (
        $fell(o_mem_oe_n) |-> !o_mem_oe_n [*8] ##15 !o_mem_oe_n
        ##1 o_mem_oe_n)
        else $error("Read cycle length wrong.");
    chk_addr_at_cs: assert property (
        (!o_mem_cs_n && !$fell(o_mem_cs_n)) |-> $stable(o_mem_addr))
        else $error("Address moved while selected.");
    chk_write_pulse: assert property (
        s_wr_start |-> (!o_mem_we_n && !o_mem_cs_n) [*8] ##6
        (!o_mem_we_n && !o_mem_cs_n) ##1 (o_mem_we_n && o_mem_cs_n))
        else $error("Write pulse length wrong.");
    chk_write_data: assert property (
        s_wr_start |-> o_mem_dq_oe [*8] ##7 o_mem_dq_oe ##1 !o_mem_dq_oe)
        else $error("Write data not held through write end.");
    chk_no_fight: assert property (
        o_mem_dq_oe |-> o_mem_oe_n)
        else $error("Host drives while memory may drive.");
    // Strobes stay high long enough that a full write cycle passes.
    chk_write_gap: assert property (
        $rose(o_mem_we_n) |-> o_mem_we_n [*6])
        else $error("Write cycles too close.");
    chk_wake_wait: assert property (
        $fell(o_asleep) |-> !o_ready [*8] ##12 !o_ready
        ##1 (o_ready || i_sleep))
        else $error("Access before retention recovery.");
    chk_sleep_desel: assert property (
        o_asleep |-> o_mem_cs_n && !o_mem_dq_oe)
        else $error("Memory selected in retention.");

endmodule

`default_nettype wire

// *** core/asr_pkg.sv ***
package asr_pkg;

    // Geometry of the memory outside.
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam int DEPTH = 2048;

    // Clock period in ns.
    localparam int CLK_NS = 10;

    // Slowest speed grade, in ns, as printed.
    localparam int READ_CYCLE_NS = 200;
    localparam int OUTPUT_ENABLE_ACCESS_TIME_NS = 70;
    localparam int DESELECT_TO_HIGH_IMPEDANCE_NS = 60;
    localparam int WRITE_TO_HIGH_IMPEDANCE_NS = 50;
    localparam int WRITE_CYCLE_NS = 200;
    localparam int CHIP_SELECT_TO_WRITE_END_NS = 120;
    localparam int ADDRESS_TO_WRITE_END_NS = 140;
    localparam int DATA_SETUP_TO_WRITE_END_NS = 50;
    localparam int DATA_HOLD_AFTER_WRITE_NS = 0;
    localparam int DESELECT_TO_RETENTION_TIME_NS = 0;
    localparam int RETENTION_RECOVERY_TIME_NS = READ_CYCLE_NS;

    // Cycle counts: least times round up, at least one cycle.
    function automatic int min_cyc(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int READ_CYC = min_cyc(READ_CYCLE_NS);
    localparam int WRITE_CYC = min_cyc(WRITE_CYCLE_NS);
    localparam int CS_WRITE_CYC = min_cyc(CHIP_SELECT_TO_WRITE_END_NS);
    localparam int ADDR_WRITE_CYC = min_cyc(ADDRESS_TO_WRITE_END_NS);
    localparam int DATA_WRITE_CYC = min_cyc(DATA_SETUP_TO_WRITE_END_NS);
    localparam int HIZ_CYC = min_cyc(DESELECT_TO_HIGH_IMPEDANCE_NS);
    localparam int RECOVER_CYC = min_cyc(RETENTION_RECOVERY_TIME_NS);
    localparam int CNT_W = 8;

    // Pins toward the memory.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic cs_n;
        logic oe_n;
        logic we_n;
    } asr_pins_t;

    // Controller states.
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_READ = 6'h02,
        ST_WRITE = 6'h04,
        ST_GAP = 6'h08,
        ST_SLEEP = 6'h10,
        ST_WAKE = 6'h20
    } asr_state_t;

endpackage

// *** testbench/asr_sram.sv ***
`timescale 1ns/1ns
`default_nettype none
// Memory model at the slowest grade. Data that is not yet valid reads as
// junk, so an early sample shows up.
module asr_sram (
    input wire logic [10:0] i_a,
    input wire logic i_cs_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic [7:0] i_d,
    input wire logic i_d_oe,
    output logic [7:0] o_q,
    output logic o_clash
);
    logic [7:0] mem [2048];
    logic drv = 1'b0;
    logic [7:0] junk = 8'h3c;
    logic [7:0] held;
    time t_s = 0;
    time t_a = 0;
    time t_d = 0;
    time t_c = 0;
    wire en = !i_cs_n && !i_oe_n && i_we_n;
    wire wr = !i_cs_n && !i_we_n;
    initial o_clash = 1'b0;
    // Drive late after select; release just inside the limit.
    always @(en) begin
        if (en) drv <= #10 1'b1;
        else drv <= #59 1'b0;
    end
    always @(i_a, en) t_s = $time;
    always @(i_a) t_a = $time;
    always @(i_d, i_d_oe) t_d = $time;
    always @(negedge i_cs_n) t_c = $time;
    // Old data lasts only the hold time; a floating bus keeps moving.
    always #1 begin
        junk = junk + 8'h1d;
        if ($time - t_s >= 200) held = mem[i_a];
        if (drv && i_d_oe) o_clash = 1'b1;
        if (i_d_oe) o_q = i_d;
        else if (drv && ($time - t_s < 20 || $time - t_s >= 200)) o_q = held;
        else o_q = junk;
    end
    // The byte lands when the first strobe rises; short setup stores junk.
    always @(negedge wr) begin
        if (i_d_oe && $time - t_a >= 140 && $time - t_d >= 50
            && $time - t_c >= 120)
            mem[i_a] = i_d;
        else
            mem[i_a] = 8'hxx;
    end
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
// Bench: requests in at the falling edge, memory model on the pins.
module tb;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_req = 1'b0;
    logic i_write = 1'b0;
    logic i_sleep = 1'b0;
    logic [10:0] i_addr = 11'h000;
    logic [7:0] i_wdata = 8'h00;
    logic ready, rvalid, asleep, cs_n, oe_n, we_n, dq_oe, clash;
    logic [7:0] rdata, hq, bus;
    logic [10:0] ma;
    int mismatches = 0;
    int checks = 0;
    asr_host dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(i_req),
        .i_write(i_write), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_sleep(i_sleep), .o_ready(ready), .o_rvalid(rvalid),
        .o_rdata(rdata), .o_asleep(asleep), .o_mem_addr(ma),
        .o_mem_cs_n(cs_n), .o_mem_oe_n(oe_n), .o_mem_we_n(we_n),
        .i_mem_dq(bus), .o_mem_dq(hq), .o_mem_dq_oe(dq_oe));
    asr_sram mem (.i_a(ma), .i_cs_n(cs_n), .i_oe_n(oe_n), .i_we_n(we_n),
        .i_d(hq), .i_d_oe(dq_oe), .o_q(bus), .o_clash(clash));
    initial forever #5 i_clk = ~i_clk;
    task automatic check(input logic [10:0] seen, input logic [10:0] want);
        checks++;
        if (seen !== want) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                seen, want);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Bounded wait for the port to accept; a hang ends the run.
    task automatic wait_ready();
        for (int n = 0; ready !== 1'b1; n++) begin
            if (n > 60) begin
                check(1'b0, 1'b1);
                tally_and_finish();
            end
            @(negedge i_clk);
        end
    endtask
    // Hold the request to the taking edge, then spoil the inputs.
    task automatic issue(input logic w, input logic [10:0] a,
        input logic [7:0] d);
        wait_ready();
        i_req = 1'b1;
        i_write = w;
        i_addr = a;
        i_wdata = d;
        @(negedge i_clk);
        i_req = 1'b0;
        i_addr = ~a;
        i_wdata = ~d;
    endtask
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        issue(1'b1, a, d);
        repeat (2) @(negedge i_clk);
        check(oe_n, 1'b1);
        check(dq_oe, 1'b1);
        check(ma, a);
        check(cs_n | we_n, 1'b0);
    endtask
    // Read and compare; the strobes are watched while it runs.
    task automatic rd(input logic [10:0] a, input logic [7:0] want);
        int n;
        n = 0;
        issue(1'b0, a, 8'h00);
        while (rvalid !== 1'b1 && n < 40) begin
            check(we_n, 1'b1);
            if (cs_n === 1'b0) check(ma, a);
            @(negedge i_clk);
            n++;
        end
        check(rvalid, 1'b1);
        if (n >= 40) tally_and_finish();
        check(rdata, want);
        @(negedge i_clk);
        check(rvalid, 1'b0);
        check(rdata, want);
    endtask
    // Pins while reset is held, then release after two cycles' worth.
    task automatic reset_state();
        @(negedge i_clk);
        check(cs_n, 1'b1);
        check(oe_n, 1'b1);
        check(we_n, 1'b1);
        check(dq_oe, 1'b0);
        check(rvalid, 1'b0);
        @(negedge i_clk);
        i_nrst = 1'b1;
    endtask
    // Four patterns written, then read back newest first.
    task automatic fill_and_read();
        logic [10:0] ta [4];
        logic [7:0] td [4];
        ta = '{11'h000, 11'h7ff, 11'h555, 11'h2aa};
        td = '{8'h00, 8'hff, 8'ha5, 8'h5a};
        for (int i = 0; i < 4; i++) wr(ta[i], td[i]);
        for (int i = 3; i >= 0; i--) rd(ta[i], td[i]);
    endtask
    // Two writes to one address back to back; the later one must win.
    task automatic overwrite();
        wr(11'h123, 8'h11);
        wr(11'h123, 8'hee);
        rd(11'h123, 8'hee);
    endtask
    // A write asked for while a read is busy must be ignored.
    task automatic refused_write();
        issue(1'b0, 11'h555, 8'h00);
        @(negedge i_clk);
        i_req = 1'b1;
        i_write = 1'b1;
        i_addr = 11'h2aa;
        i_wdata = 8'hc3;
        repeat (5) @(negedge i_clk);
        check(ready, 1'b0);
        check(ma, 11'h555);
        i_req = 1'b0;
        rd(11'h2aa, 8'h5a);
    endtask
    // Retention, then the recovery wait before the next access.
    task automatic sleep_and_wake();
        int n;
        wait_ready();
        i_sleep = 1'b1;
        repeat (2) @(negedge i_clk);
        check(asleep, 1'b1);
        check(cs_n, 1'b1);
        i_sleep = 1'b0;
        n = 0;
        while (ready !== 1'b1 && n < 60) begin
            @(negedge i_clk);
            n++;
        end
        check(n >= asr_pkg::RECOVER_CYC && n < 60, 1'b1);
        if (n >= 60) tally_and_finish();
        rd(11'h7ff, 8'hff);
    endtask
    initial begin
        reset_state();
        fill_and_read();
        overwrite();
        refused_write();
        sleep_and_wake();
        check(clash, 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
